// File: verilog/lba_top.sv
// Behaviour
// - with no source selected, no current alarms; load and leakage values follow live current.
// - only logic or relay switched outputs may be the current source.
// - source choices are outputs one to four; three only when fitted as relay.
// - current is sampled separately in on and off states of the source output.
// - range setting accepts 10.0 to 999.9 A and resets to 100.0 A.
// - range setting is applied only while a source is selected.
// - leakage and over-current thresholds raise their alarms when crossed.
// - non-latching alarms clear by themselves when the cause is gone.
// - auto latch accepts ack anytime; clears once acked and safe.
// - manual latch ignores ack until the fault is removed.
// - loop break declared when process value misses its response time.
// - loop-break time is off by default or 1 to 9999 seconds.
// - break alarms routable onto alarm outputs one, two or three.
// - routed break alarms OR with other alarms on the same output.
//
// Decided for this implementation: the strobed register port and the address map.
module lba_top
    import lba_pkg::*;
#(
    parameter int SECOND_CYCLES = CYCLES_PER_SECOND
)
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // measurement path
    input wire logic [13:0] i_current,
    input wire logic [3:0] i_out_demand,
    input wire logic [3:0] i_out_is_dc,
    input wire logic i_out3_relay_fitted,
    input wire logic i_output_change,
    input wire logic i_pv_response,
    // operator and alarm routing
    input wire logic i_ack,
    input wire logic [2:0] i_other_alarms,
    output logic o_alarm_output_one,
    output logic o_alarm_output_two,
    output logic o_alarm_output_three,
    output logic [13:0] o_load_current,
    output logic [13:0] o_leak_current,
    output logic o_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [3:0] dem_s1, dem_s2;
    logic chg_s1, chg_s2, rsp_s1, rsp_s2, ack_s1, ack_s2, ack_d;
    logic [2:0] oth_s1, oth_s2;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            dem_s1 <= 4'h0;
            dem_s2 <= 4'h0;
            chg_s1 <= 1'b0;
            chg_s2 <= 1'b0;
            rsp_s1 <= 1'b0;
            rsp_s2 <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_d <= 1'b0;
            oth_s1 <= 3'h0;
            oth_s2 <= 3'h0;
        end else begin
            dem_s1 <= i_out_demand;
            dem_s2 <= dem_s1;
            chg_s1 <= i_output_change;
            chg_s2 <= chg_s1;
            rsp_s1 <= i_pv_response;
            rsp_s2 <= rsp_s1;
            ack_s1 <= i_ack;
            ack_s2 <= ack_s1;
            ack_d <= ack_s2;
            oth_s1 <= i_other_alarms;
            oth_s2 <= oth_s1;
        end
    end
    // ack pulse: rising edge so a longer press still counts once
    logic ack_pulse;
    assign ack_pulse = ack_s2 && !ack_d;

    ////////////////////////////////////////////////////////////////////////////
    // settings
    logic [2:0] current_source_select;
    logic [1:0] current_alarm_latch_mode;
    logic [2:0] break_alarm_routing;
    logic [13:0] current_range_setting;
    logic [13:0] leak_th, over_th, load_th;
    logic [13:0] loop_break_time;
    logic [N_ALARMS-1:0] irq_stat, irq_mask;

    // a write outside the legal set leaves the old value in place
    logic src_ok;
    always_comb begin
        unique case (i_wdata[CFG_SRC_LSB +: 3])
            SRC_NONE: src_ok = 1'b1;
            SRC_OUT1: src_ok = !i_out_is_dc[0];
            SRC_OUT2: src_ok = !i_out_is_dc[1];
            SRC_OUT3: src_ok = i_out3_relay_fitted;
            SRC_OUT4: src_ok = !i_out_is_dc[3];
            default: src_ok = 1'b0;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            current_source_select <= CONFIG_RESET[CFG_SRC_LSB +: 3];
            current_alarm_latch_mode <= CONFIG_RESET[CFG_MODE_LSB +: 2];
            break_alarm_routing <= CONFIG_RESET[CFG_ROUTE_LSB +: 3];
        end else if (i_wr && i_addr == ADDR_CONFIG) begin
            if (src_ok) begin
                current_source_select <= i_wdata[CFG_SRC_LSB +: 3];
            end
            if (i_wdata[CFG_MODE_LSB +: 2] <= LATCH_MANUAL) begin
                current_alarm_latch_mode <= i_wdata[CFG_MODE_LSB +: 2];
            end
            break_alarm_routing <= i_wdata[CFG_ROUTE_LSB +: 3];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            current_range_setting <= RANGE_RESET;
        end else if (i_wr && i_addr == ADDR_RANGE && i_wdata[13:0] >= RANGE_MIN
                     && i_wdata[13:0] <= RANGE_MAX && i_wdata[15:14] == 2'h0) begin
            current_range_setting <= i_wdata[13:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            leak_th <= TH_RESET[13:0];
            over_th <= TH_RESET[13:0];
            load_th <= TH_RESET[13:0];
        end else if (i_wr) begin
            if (i_addr == ADDR_LEAK_TH) leak_th <= i_wdata[13:0];
            if (i_addr == ADDR_OVER_TH) over_th <= i_wdata[13:0];
            if (i_addr == ADDR_LOAD_TH) load_th <= i_wdata[13:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            loop_break_time <= LB_TIME_OFF;
        end else if (i_wr && i_addr == ADDR_LB_TIME && i_wdata[13:0] <= LB_TIME_MAX
                     && i_wdata[15:14] == 2'h0) begin
            loop_break_time <= i_wdata[13:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // current sampling in step with the source output demand
    logic ct_on;
    logic src_demand;
    assign ct_on = current_source_select != SRC_NONE;
    always_comb begin
        unique case (current_source_select)
            SRC_OUT1: src_demand = dem_s2[0];
            SRC_OUT2: src_demand = dem_s2[1];
            SRC_OUT3: src_demand = dem_s2[2];
            SRC_OUT4: src_demand = dem_s2[3];
            default: src_demand = 1'b0;
        endcase
    end

    // readings above the range are clipped to the nominal rating
    logic [13:0] cur_scaled;
    assign cur_scaled = (ct_on && i_current > current_range_setting) ?
                        current_range_setting : i_current;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_load_current <= 14'h0000;
            o_leak_current <= 14'h0000;
        end else if (!ct_on) begin
            o_load_current <= i_current;
            o_leak_current <= i_current;
        end else if (src_demand) begin
            o_load_current <= cur_scaled;
        end else begin
            o_leak_current <= cur_scaled;
        end
    end

    // the readings are registered, so judge each one against the demand it was taken with;
    // the live demand would pair a new on-state with the last on-period's reading
    logic demand_d;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            demand_d <= 1'b0;
        end else begin
            demand_d <= src_demand;
        end
    end

    logic [2:0] cur_fault;
    always_comb begin
        cur_fault[AL_LEAK] = ct_on && !demand_d && o_leak_current > leak_th;
        cur_fault[AL_OVER] = ct_on && demand_d && o_load_current > over_th;
        cur_fault[AL_LOAD] = ct_on && demand_d && o_load_current < load_th;
    end

    logic [2:0] cur_alarm;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_latch
            lba_latch u_latch (
                .i_ref_clk(i_ref_clk),
                .i_resetn(i_resetn && ct_on),
                .i_mode(current_alarm_latch_mode),
                .i_fault(cur_fault[g]),
                .i_ack(ack_pulse),
                .o_alarm(cur_alarm[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // loop-break timer
    lba_lb_state_type lb_state;
    logic [26:0] sec_cnt;
    logic [13:0] lb_secs;
    logic lb_alarm;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || loop_break_time == LB_TIME_OFF) begin
            lb_state <= LB_IDLE;
            sec_cnt <= 27'h0000000;
            lb_secs <= 14'h0000;
        end else if (chg_s2) begin
            lb_state <= LB_RUN;
            sec_cnt <= 27'h0000000;
            lb_secs <= 14'h0000;
        end else begin
            unique case (lb_state)
                LB_IDLE: begin
                end
                LB_RUN: begin
                    if (rsp_s2) begin
                        lb_state <= LB_IDLE;
                    end else if (sec_cnt == 27'(SECOND_CYCLES - 1)) begin
                        sec_cnt <= 27'h0000000;
                        lb_secs <= lb_secs + 14'h0001;
                        if (lb_secs + 14'h0001 >= loop_break_time) begin
                            lb_state <= LB_TRIP;
                        end
                    end else begin
                        sec_cnt <= sec_cnt + 27'h0000001;
                    end
                end
                LB_TRIP: begin
                    if (rsp_s2) begin
                        lb_state <= LB_IDLE;
                    end
                end
            endcase
        end
    end
    assign lb_alarm = lb_state == LB_TRIP;

    ////////////////////////////////////////////////////////////////////////////
    // routing, interrupts, read port
    logic [N_ALARMS-1:0] alarms;
    logic brk_any;
    assign alarms = {lb_alarm, cur_alarm};
    assign brk_any = |alarms;
    assign o_alarm_output_one = oth_s2[0] || (break_alarm_routing[0] && brk_any);
    assign o_alarm_output_two = oth_s2[1] || (break_alarm_routing[1] && brk_any);
    assign o_alarm_output_three = oth_s2[2] || (break_alarm_routing[2] && brk_any);

    logic [N_ALARMS-1:0] alarms_d;
    logic stat_rd;
    assign stat_rd = i_rd && i_addr == ADDR_IRQ_STAT;
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            alarms_d <= '0;
            irq_stat <= '0;
        end else begin
            alarms_d <= alarms;
            // a new event in the read cycle survives the clear
            irq_stat <= (stat_rd ? '0 : irq_stat) | (alarms & ~alarms_d);
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            irq_mask <= '0;
        end else if (i_wr && i_addr == ADDR_IRQ_MASK) begin
            irq_mask <= i_wdata[N_ALARMS-1:0];
        end
    end
    assign o_irq = |(irq_stat & irq_mask);

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            unique case (i_addr)
                ADDR_CONFIG: o_rdata <= {3'h0, i_out3_relay_fitted, 1'h0, break_alarm_routing,
                                         2'h0, current_alarm_latch_mode, 1'h0,
                                         current_source_select};
                ADDR_RANGE: o_rdata <= {2'h0, current_range_setting};
                ADDR_LEAK_TH: o_rdata <= {2'h0, leak_th};
                ADDR_OVER_TH: o_rdata <= {2'h0, over_th};
                ADDR_LOAD_TH: o_rdata <= {2'h0, load_th};
                ADDR_LB_TIME: o_rdata <= {2'h0, loop_break_time};
                ADDR_STATUS: o_rdata <= {12'h000, alarms};
                ADDR_IRQ_STAT: o_rdata <= {12'h000, irq_stat};
                ADDR_IRQ_MASK: o_rdata <= {12'h000, irq_mask};
                ADDR_ON_CUR: o_rdata <= {2'h0, o_load_current};
                ADDR_OFF_CUR: o_rdata <= {2'h0, o_leak_current};
                default: o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule : lba_top

// File: verilog/lba_pkg.sv
package lba_pkg;
    // current source selector codes
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_OUT1 = 3'h1;
    localparam logic [2:0] SRC_OUT2 = 3'h2;
    localparam logic [2:0] SRC_OUT3 = 3'h3;
    localparam logic [2:0] SRC_OUT4 = 3'h4;
    // latch mode codes
    localparam logic [1:0] LATCH_NONE = 2'h0;
    localparam logic [1:0] LATCH_AUTO = 2'h1;
    localparam logic [1:0] LATCH_MANUAL = 2'h2;
    // current values in tenths of an ampere
    localparam logic [13:0] RANGE_MIN = 14'h0064;
    localparam logic [13:0] RANGE_MAX = 14'h270F;
    localparam logic [13:0] RANGE_RESET = 14'h03E8;
    // loop-break time in seconds, zero means off
    localparam logic [13:0] LB_TIME_OFF = 14'h0000;
    localparam logic [13:0] LB_TIME_MAX = 14'h270F;
    localparam int CLK_HZ = 100000000;
    localparam int SECOND_NS = 1000000000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
    // register map
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_RANGE = 4'h1;
    localparam logic [3:0] ADDR_LEAK_TH = 4'h2;
    localparam logic [3:0] ADDR_OVER_TH = 4'h3;
    localparam logic [3:0] ADDR_LOAD_TH = 4'h4;
    localparam logic [3:0] ADDR_LB_TIME = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h7;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
    localparam logic [3:0] ADDR_ON_CUR = 4'h9;
    localparam logic [3:0] ADDR_OFF_CUR = 4'hA;
    // config field positions
    localparam int CFG_SRC_LSB = 0;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_ROUTE_LSB = 8;
    localparam int CFG_RELAY3_BIT = 12;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [15:0] TH_RESET = 16'h0000;
    // alarm bit positions: leak, load, over, loop break
    localparam int N_ALARMS = 4;
    localparam int AL_LEAK = 0;
    localparam int AL_LOAD = 1;
    localparam int AL_OVER = 2;
    localparam int AL_LB = 3;
    typedef enum logic [2:0] {
        LB_IDLE = 3'b001,
        LB_RUN = 3'b010,
        LB_TRIP = 3'b100
    } lba_lb_state_type;
endpackage : lba_pkg

// File: verilog/lba_latch.sv
module lba_latch
    import lba_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // control
    input wire logic [1:0] i_mode,
    input wire logic i_fault,
    input wire logic i_ack,
    // alarm
    output logic o_alarm
);
    logic held;
    logic ack_seen;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            ack_seen <= 1'b0;
        end else if (i_mode != LATCH_AUTO || !held) begin
            ack_seen <= 1'b0;
        end else if (i_ack) begin
            ack_seen <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            held <= 1'b0;
        end else if (i_fault) begin
            held <= 1'b1;
        end else begin
            unique case (i_mode)
                LATCH_AUTO: begin
                    if (ack_seen || i_ack) begin
                        held <= 1'b0;
                    end
                end
                LATCH_MANUAL: begin
                    // ack while the fault stands is dropped here, not remembered
                    if (i_ack) begin
                        held <= 1'b0;
                    end
                end
                default: begin
                    held <= 1'b0;
                end
            endcase
        end
    end

    assign o_alarm = held;
endmodule : lba_latch

// File: verif/lba_top_sva.sv
module lba_top_sva
    import lba_pkg::*;
(
    // watched ports
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [13:0] i_current,
    input wire logic [3:0] i_out_is_dc,
    input wire logic i_out3_relay_fitted,
    input wire logic [2:0] i_other_alarms,
    input wire logic o_alarm_output_one,
    input wire logic [13:0] o_load_current,
    input wire logic [13:0] o_leak_current,
    input wire logic o_irq
);
    logic src_none;
    logic route_one;
    logic [3:0] mask;
    logic [2:0] code;
    logic legal;
    ////////////////////////////////////////
    // shadow of the written settings; refused source codes leave the old choice in place
    assign code = i_wdata[2:0];
    assign legal = code != 3'h0 && code <= 3'h4 && !i_out_is_dc[code[1:0] - 2'h1]
        && (code != 3'h3 || i_out3_relay_fitted);
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            src_none <= 1'b1;
            route_one <= 1'b0;
        end else if (i_wr && i_addr == ADDR_CONFIG) begin
            route_one <= i_wdata[CFG_ROUTE_LSB];
            if (code == SRC_NONE || legal) begin
                src_none <= code == SRC_NONE;
            end
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            mask <= 4'h0;
        end else if (i_wr && i_addr == ADDR_IRQ_MASK) begin
            mask <= i_wdata[3:0];
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);
    // four cycles cover the input synchronisers and the output register
    sequence s_other_held;
        (i_resetn && i_other_alarms[0])[*4];
    endsequence
    sequence s_one_quiet;
        (i_resetn && !route_one && !i_other_alarms[0])[*4];
    endsequence
    sequence s_live_steady;
        (i_resetn && src_none && $stable(i_current))[*4];
    endsequence
    read_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside the answer cycle");
    unmapped_read_a: assert property ($past(i_rd) && $past(i_addr) > ADDR_OFF_CUR
        |-> o_rdata == 16'h0000) else $error("unmapped read not zero");
    reset_quiet_a: assert property ($rose(i_resetn) |-> o_rdata == 16'h0000 && !o_irq
        && o_load_current == 14'h0000 && o_leak_current == 14'h0000)
        else $error("outputs not cleared by reset");
    reset_alarm_a: assert property ($rose(i_resetn) |-> !o_alarm_output_one)
        else $error("alarm output high after reset");
    other_or_a: assert property (s_other_held |-> o_alarm_output_one)
        else $error("other alarm not passed to alarm output one");
    unrouted_a: assert property (s_one_quiet |-> !o_alarm_output_one)
        else $error("alarm output one high with nothing routed");
    live_follow_a: assert property (s_live_steady |-> o_load_current == i_current
        && o_leak_current == i_current) else $error("readings do not follow live current");
    irq_masked_a: assert property (mask == 4'h0 |-> !o_irq)
        else $error("interrupt high while fully masked");
endmodule : lba_top_sva
bind lba_top lba_top_sva lba_top_sva_i (
    .i_ref_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_current,
    .i_out_is_dc, .i_out3_relay_fitted, .i_other_alarms, .o_alarm_output_one,
    .o_load_current, .o_leak_current, .o_irq
);

// File: verif/lba_ct_model.sv
module lba_ct_model #(
    parameter int LOAD_OUT = 0
)
(
    // clock and switched outputs
    input wire logic i_ref_clk,
    input wire logic [3:0] i_out_demand,
    // load current levels in tenths of an ampere
    input wire logic [13:0] i_on_level,
    input wire logic [13:0] i_off_level,
    // transformer reading
    output logic [13:0] o_current
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] settling = 14'h0000;
    initial o_current = 14'h0000;
    // the reading trails the demand by two cycles, as long as the demand synchronisers
    always @(posedge i_ref_clk) begin
        settling <= i_out_demand[LOAD_OUT] ? i_on_level : i_off_level;
        o_current <= settling;
    end
endmodule : lba_ct_model

// File: verif/lba_top_test.sv
module lba_top_test
    import lba_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SEC = 10;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [3:0] i_out_demand = 4'h0;
    logic [3:0] i_out_is_dc = 4'h0;
    logic i_out3_relay_fitted = 1'b0;
    logic [2:0] i_other_alarms = 3'h0;
    logic [2:0] pins = 3'h0;
    logic [13:0] on_level = 14'h0000;
    logic [13:0] off_level = 14'h0000;
    wire i_ack, i_pv_response, i_output_change;
    logic [15:0] o_rdata, rv;
    logic [13:0] i_current, o_load_current, o_leak_current;
    logic o_alarm_output_one, o_alarm_output_two, o_alarm_output_three, o_irq;
    int fail_count = 0;
    int samples_checked = 0;
    assign {i_ack, i_pv_response, i_output_change} = pins;
    always #5 i_ref_clk = ~i_ref_clk;
    lba_top #(.SECOND_CYCLES(SEC)) lba_top_i (.*);
    lba_ct_model lba_ct_model_i (.i_ref_clk, .i_out_demand, .i_on_level(on_level),
        .i_off_level(off_level), .o_current(i_current));
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] e, input logic [15:0] g, input string what);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask : rd
    task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
        rd(a);
        chk(e, rv, "register");
    endtask : chk_reg
    // polls, since the pins pass synchronisers before the alarm logic sees them
    task automatic chk_stat(input int b, input logic v);
        rd(ADDR_STATUS);
        for (int k = 0; k < 40 && rv[b] !== v; k++) begin
            rd(ADDR_STATUS);
        end
        chk({15'h0000, v}, {15'h0000, rv[b]}, "status bit");
    endtask : chk_stat
    task automatic chk_al(input logic [2:0] e);
        #1;
        chk({13'h0000, e}, {13'h0000, o_alarm_output_three, o_alarm_output_two,
            o_alarm_output_one}, "alarm outputs");
    endtask : chk_al
    task automatic pulse(input logic [2:0] m);
        @(posedge i_ref_clk);
        pins <= m;
        @(posedge i_ref_clk);
        pins <= 3'h0;
    endtask : pulse
    task automatic cl(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask : cl
    ////////////////////////////////////////
    task automatic t_regs();
        logic [15:0] wv [4] = '{16'h0063, 16'h2710, 16'h0064, 16'h270F};
        logic [15:0] ev [4] = '{16'h03E8, 16'h03E8, 16'h0064, 16'h270F};
        chk_reg(ADDR_RANGE, {2'b00, RANGE_RESET});
        chk_reg(ADDR_LB_TIME, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_RANGE, wv[k]);
            chk_reg(ADDR_RANGE, ev[k]);
        end
        wr(ADDR_LB_TIME, 16'h2710);
        chk_reg(ADDR_LB_TIME, 16'h0000);
        wr(ADDR_LB_TIME, 16'h270F);
        chk_reg(ADDR_LB_TIME, 16'h270F);
        chk_reg(4'hF, 16'h0000);
    endtask : t_regs
    task automatic t_source();
        logic [2:0] cv [6] = '{3'h2, 3'h3, 3'h5, 3'h7, 3'h4, 3'h1};
        logic [2:0] ev [6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h1};
        i_out_is_dc <= 4'h2;
        cl(3);
        for (int k = 0; k < 6; k++) begin
            wr(ADDR_CONFIG, {13'h0000, cv[k]});
            chk_reg(ADDR_CONFIG, {13'h0000, ev[k]});
        end
        i_out3_relay_fitted <= 1'b1;
        i_out_is_dc <= 4'h0;
        cl(3);
        wr(ADDR_CONFIG, 16'h0003);
        chk_reg(ADDR_CONFIG, 16'h1003);
        wr(ADDR_CONFIG, 16'h0002);
        chk_reg(ADDR_CONFIG, 16'h1002);
    endtask : t_source
    task automatic t_live();
        wr(ADDR_CONFIG, 16'h0000);
        wr(ADDR_RANGE, 16'h012C);
        wr(ADDR_OVER_TH, 16'h000A);
        wr(ADDR_LEAK_TH, 16'h000A);
        off_level <= 14'h04D2;
        cl(6);
        chk(16'h04D2, {2'b00, o_load_current}, "load current");
        chk(16'h04D2, {2'b00, o_leak_current}, "leak current");
        chk_reg(ADDR_STATUS, 16'h0000);
    endtask : t_live
    task automatic t_current();
        wr(ADDR_CONFIG, 16'h0001);
        wr(ADDR_RANGE, 16'h270F);
        wr(ADDR_OVER_TH, 16'h01F4);
        wr(ADDR_LEAK_TH, 16'h0032);
        wr(ADDR_IRQ_MASK, 16'h0004);
        on_level <= 14'h0258;
        off_level <= 14'h0014;
        i_out_demand <= 4'h1;
        chk_stat(AL_OVER, 1'b1);
        cl(2);
        chk(16'h0001, {15'h0000, o_irq}, "irq");
        chk(16'h0258, {2'b00, o_load_current}, "load current");
        i_out_demand <= 4'h0;
        off_level <= 14'h0050;
        chk_stat(AL_LEAK, 1'b1);
        chk_stat(AL_OVER, 1'b0);
        chk(16'h0258, {2'b00, o_load_current}, "load current");
        chk(16'h0050, {2'b00, o_leak_current}, "leak current");
        off_level <= 14'h0014;
        chk_stat(AL_LEAK, 1'b0);
        rd(ADDR_IRQ_STAT);
        chk(16'h0004, rv & 16'h0004, "irq status");
        rd(ADDR_IRQ_STAT);
        chk(16'h0000, rv & 16'h0004, "irq status");
        chk(16'h0000, {15'h0000, o_irq}, "irq");
        i_out_demand <= 4'h1;
        wr(ADDR_RANGE, 16'h012C);
        cl(6);
        chk(16'h012C, {2'b00, o_load_current}, "clipped load");
        wr(ADDR_LOAD_TH, 16'h0190);
        chk_stat(AL_LOAD, 1'b1);
        chk_reg(ADDR_ON_CUR, 16'h012C);
        wr(ADDR_LOAD_TH, 16'h0000);
        i_out_demand <= 4'h0;
    endtask : t_current
    task automatic t_latch();
        wr(ADDR_RANGE, 16'h270F);
        wr(ADDR_CONFIG, 16'h0011);
        i_out_demand <= 4'h1;
        chk_stat(AL_OVER, 1'b1);
        pulse(3'h4);
        cl(6);
        i_out_demand <= 4'h0;
        chk_stat(AL_OVER, 1'b0);
        wr(ADDR_CONFIG, 16'h0021);
        i_out_demand <= 4'h1;
        chk_stat(AL_OVER, 1'b1);
        pulse(3'h4);
        cl(6);
        i_out_demand <= 4'h0;
        cl(10);
        chk_stat(AL_OVER, 1'b1);
        pulse(3'h4);
        chk_stat(AL_OVER, 1'b0);
        wr(ADDR_CONFIG, 16'h0031);
        chk_reg(ADDR_CONFIG, 16'h1021);
    endtask : t_latch
    task automatic t_loop();
        wr(ADDR_CONFIG, 16'h0100);
        wr(ADDR_LB_TIME, 16'h0002);
        pulse(3'h1);
        cl(12);
        chk_al(3'h0);
        cl(20);
        chk_al(3'h1);
        chk_stat(AL_LB, 1'b1);
        pulse(3'h2);
        cl(6);
        chk_al(3'h0);
        pulse(3'h1);
        cl(15);
        pulse(3'h1);
        cl(15);
        chk_al(3'h0);
        cl(15);
        chk_al(3'h1);
        for (int r = 0; r < 3; r++) begin
            wr(ADDR_CONFIG, 16'h0100 << r);
            cl(2);
            chk_al(3'h1 << r);
        end
        i_other_alarms <= 3'h1;
        cl(5);
        chk_al(3'h5);
        pulse(3'h2);
        i_other_alarms <= 3'h0;
        wr(ADDR_LB_TIME, 16'h0000);
        pulse(3'h1);
        cl(40);
        chk_al(3'h0);
    endtask : t_loop
    ////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        t_regs();
        t_source();
        t_live();
        t_current();
        t_latch();
        t_loop();
        print_verdict();
    end
    // the whole sequence needs a few hundred cycles
    initial begin
        #100000;
        fail_count++;
        print_verdict();
    end
endmodule : lba_top_test
